// [tb/lpas_host_model.sv]
module lpas_host_model (
	// bus
	input wire logic sys_clk,
	input wire logic [31:0] regRdData,
	input wire logic regRdValid,
	output logic [15:0] regAddr,
	output logic regWrEn,
	output logic [31:0] regWrData,
	output logic regRdEn
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		regAddr = 16'h0000;
		regWrEn = 1'b0;
		regWrData = 32'h0;
		regRdEn = 1'b0;
	end
	// idle bus shows inverted values so stale ones never pass
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge sys_clk);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		@(negedge sys_clk);
		regWrEn = 1'b0;
		regAddr = ~a;
		regWrData = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
		@(negedge sys_clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge sys_clk);
		ok = regRdValid;
		d = regRdData;
		regRdEn = 1'b0;
		regAddr = ~a;
	endtask
endmodule

// [tb/lpas_line_monitor_bench.sv]
module lpas_line_monitor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] zxVoltRise = 3'h0;
	logic [2:0] zxVoltFall = 3'h0;
	logic [2:0] zxCurrRise = 3'h0;
	logic signed [23:0] phaseVoltA = 24'h0;
	logic signed [23:0] phaseVoltB = 24'h0;
	logic signed [23:0] phaseVoltC = 24'h0;
	logic [15:0] regAddr;
	logic regWrEn;
	logic regRdEn;
	logic regRdValid;
	logic event_interrupt_n;
	logic [31:0] regWrData;
	logic [31:0] regRdData;
	logic [31:0] rdv;
	logic ok;
	logic riseNext = 1'b1;
	int n_mismatch = 0;
	int num_checks = 0;
	int halfLen;
	int d1;
	int d2;
	always #25 sys_clk = ~sys_clk;
	lpas_line_monitor u_lpas_line_monitor (.sys_clk, .rst_n, .zxVoltRise, .zxVoltFall, .zxCurrRise,
		.phaseVoltA, .phaseVoltB, .phaseVoltC, .regAddr, .regWrEn, .regWrData, .regRdEn,
		.regRdData, .regRdValid, .event_interrupt_n);
	lpas_host_model u_lpas_host_model (.sys_clk, .regRdData, .regRdValid, .regAddr, .regWrEn,
		.regWrData, .regRdEn);
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic get(input logic [15:0] a);
		u_lpas_host_model.rd(a, rdv, ok);
		chk(ok, 1'b1);
		if (ok !== 1'b1)
			report_and_stop();
	endtask
	task automatic rchk(input logic [15:0] a, input logic [31:0] m, input logic [31:0] exp);
		get(a);
		chk(rdv & m, exp);
	endtask
	// delay and period results may be one tick off the ideal count
	task automatic near(input logic [15:0] a, input int cyc);
		int t;
		t = cyc * 256 / 20000;
		get(a);
		chk(rdv >= t - 1 && rdv <= t + 1, 1'b1);
	endtask
	function automatic logic signed [23:0] volt(input logic below);
		logic signed [23:0] m;
		m = below ? 24'($urandom_range(12'hFFF)) : 24'($urandom_range(16'h1FFF, 16'h1000));
		return $urandom_range(1) ? m : -m;
	endfunction
	// restart first so the gap before this call never makes a mixed first period
	task automatic run(input logic [2:0] below, input int n);
		u_lpas_host_model.wr(16'hE704, 32'h2);
		repeat (n) begin
			phaseVoltA = volt(below[0]);
			phaseVoltB = volt(below[1]);
			phaseVoltC = volt(below[2]);
			repeat (halfLen) @(negedge sys_clk);
			if (riseNext)
				zxVoltRise = 3'h7;
			else
				zxVoltFall = 3'h7;
			riseNext = !riseNext;
			@(negedge sys_clk);
			zxVoltRise = 3'h0;
			zxVoltFall = 3'h0;
		end
		repeat (3) @(negedge sys_clk);
	endtask
	task automatic vol(input logic [2:0] p, input int gap);
		zxVoltRise = p;
		@(negedge sys_clk);
		zxVoltRise = 3'h0;
		repeat (gap) @(negedge sys_clk);
	endtask
	task automatic cur(input logic [2:0] p, input int gap);
		zxCurrRise = p;
		@(negedge sys_clk);
		zxCurrRise = 3'h0;
		repeat (gap) @(negedge sys_clk);
	endtask
	initial begin
		void'($urandom(32'h1B8F));
		halfLen = $urandom_range(16'h04B0, 16'h0258);
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		chk(event_interrupt_n, 1'b1);
		rchk(16'hE704, 32'hFFFFFFFF, 32'h1);
		rchk(16'hE701, 32'hFFFFFFFF, 32'h0);
		rchk(16'hE509, 32'hFFFFFFFF, 32'h0);
		rchk(16'hE5FF, 32'hFFFFFFFF, 32'h0);
		u_lpas_host_model.wr(16'hE509, 32'h1000);
		u_lpas_host_model.wr(16'hE704, 32'h2);
		run(3'h1, 2);
		chk(event_interrupt_n, 1'b1);
		rchk(16'hE502, 32'h10000, 32'h10000);
		rchk(16'hE600, 32'h7000, 32'h1000);
		u_lpas_host_model.wr(16'hE50B, 32'h10000);
		chk(event_interrupt_n, 1'b0);
		u_lpas_host_model.wr(16'hE502, 32'h10000);
		chk(event_interrupt_n, 1'b1);
		rchk(16'hE600, 32'h7000, 32'h1000);
		run(3'h6, 2);
		chk(event_interrupt_n, 1'b0);
		rchk(16'hE600, 32'h7000, 32'h6000);
		u_lpas_host_model.wr(16'hE502, 32'h10000);
		run(3'h0, 4);
		chk(event_interrupt_n, 1'b1);
		rchk(16'hE600, 32'h7000, 32'h0);
		// read after two whole line periods, past settling
		near(16'hE905, 2 * halfLen + 2);
		near(16'hE906, 2 * halfLen + 2);
		near(16'hE907, 2 * halfLen + 2);
		u_lpas_host_model.wr(16'hE701, 32'h40);
		u_lpas_host_model.wr(16'hE704, 32'h2);
		run(3'h1, 4);
		chk(event_interrupt_n, 1'b1);
		rchk(16'hE600, 32'h7000, 32'h1000);
		run(3'h0, 2);
		chk(event_interrupt_n, 1'b0);
		rchk(16'hE600, 32'h7000, 32'h0);
		u_lpas_host_model.wr(16'hE502, 32'h10000);
		chk(event_interrupt_n, 1'b1);
		u_lpas_host_model.wr(16'hE60E, 32'h400);
		d1 = $urandom_range(16'h0400, 16'h0100);
		d2 = $urandom_range(16'h0400, 16'h0100);
		cur(3'h1, d1);
		cur(3'h2, d2);
		cur(3'h4, 4);
		near(16'hE601, d1 + d2 + 2);
		near(16'hE602, d2 + 1);
		near(16'hE603, d1 + 1);
		// voltage pairs, then same-phase voltage to current
		u_lpas_host_model.wr(16'hE60E, 32'h200);
		vol(3'h1, d2);
		vol(3'h2, d1);
		vol(3'h4, 4);
		near(16'hE601, d1 + d2 + 2);
		near(16'hE602, d1 + 1);
		near(16'hE603, d2 + 1);
		u_lpas_host_model.wr(16'hE60E, 32'h0);
		vol(3'h7, d1);
		cur(3'h1, d2);
		cur(3'h2, 4);
		cur(3'h4, 4);
		near(16'hE601, d1 + 1);
		near(16'hE602, d1 + d2 + 2);
		near(16'hE603, d1 + d2 + 7);
		report_and_stop();
	end
endmodule
bind lpas_line_monitor lpas_line_monitor_sva u_lpas_line_monitor_sva (.sys_clk, .rst_n, .zxVoltRise,
	.zxVoltFall, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid, .event_interrupt_n);

// [tb/lpas_line_monitor_sva.sv]
module lpas_line_monitor_sva (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// crossings
	input wire logic [2:0] zxVoltRise,
	input wire logic [2:0] zxVoltFall,
	// register port
	input wire logic [15:0] regAddr,
	input wire logic regWrEn,
	input wire logic [31:0] regWrData,
	input wire logic regRdEn,
	input wire logic [31:0] regRdData,
	input wire logic regRdValid,
	// interrupt
	input wire logic event_interrupt_n
);
	wire logic [2:0] zxAny = zxVoltRise | zxVoltFall;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// a crossing one cycle before the clear sets status on the clear's edge, and set wins
	sequence s_quiet;
		zxAny == 3'h0;
	endsequence
	sequence s_clear;
		regWrEn && regAddr == 16'hE502 && regWrData[16];
	endsequence
	property p_rd_valid;
		regRdEn |=> regRdValid;
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
	property p_rd_hold;
		!regRdEn |=> $stable(regRdData) && !regRdValid;
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_unmapped;
		regRdEn && regAddr == 16'hE5FF |=> regRdData == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_clear;
		s_quiet ##1 s_clear |=> event_interrupt_n;
	endproperty
	a_clear: assert property (p_clear) else $error("clear kept interrupt");
	property p_irq_hold;
		!event_interrupt_n && !regWrEn |=> !event_interrupt_n;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped");
	property p_irq_fall;
		$fell(event_interrupt_n) |-> $past(zxAny, 2) != 3'h0 || $past(zxAny) != 3'h0 || $past(regWrEn);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt without cause");
	property p_irq_rise;
		$rose(event_interrupt_n) |-> $past(regWrEn);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("interrupt released alone");
	property p_rst;
		$rose(rst_n) |-> event_interrupt_n && !regRdValid;
	endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule

// [verilog/lpas_line_monitor.sv]
`include "lpas_params.svh"
module lpas_line_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// zero-crossing detector, one-cycle pulses per phase A..C in bits 0..2
	input wire logic [2:0] zxVoltRise,
	input wire logic [2:0] zxVoltFall,
	input wire logic [2:0] zxCurrRise,
	// filtered phase voltages, signed
	input wire logic signed [23:0] phaseVoltA,
	input wire logic signed [23:0] phaseVoltB,
	input wire logic signed [23:0] phaseVoltC,
	// register port
	input wire logic [15:0] regAddr,
	input wire logic regWrEn,
	input wire logic [31:0] regWrData,
	input wire logic regRdEn,
	output logic [31:0] regRdData,
	output logic regRdValid,
	// interrupt
	output logic event_interrupt_n
);
	localparam logic [14:0] TICK_STEP = 15'(`LPAS_TICK_KHZ);
	localparam logic [14:0] TICK_MOD = 15'(`LPAS_CLK_KHZ);

	// configuration, status and read-path registers
	logic [23:0] sag_level_q;
	logic [7:0] sag_half_cycle_count_q;
	logic [7:0] accumulation_config_q;
	logic [1:0] delay_pair_select_q;
	logic sagMask_q;
	logic sagStatus_q;
	logic [31:0] rdData_q;
	logic rdValid_q;

	// 256 kHz tick from a fractional accumulator: average exact, jitter one cycle
	logic [14:0] tickAcc_q;
	logic tick_q;
	wire [15:0] tickSum = {1'b0, tickAcc_q} + {1'b0, TICK_STEP};
	wire tickWrap = tickSum >= {1'b0, TICK_MOD};

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tickAcc_q <= 15'h0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= tickWrap;
			tickAcc_q <= tickWrap ? 15'(tickSum - {1'b0, TICK_MOD}) : tickSum[14:0];
		end
	end

	// register decode
	wire wrSagLevel = regWrEn && (regAddr == `LPAS_ADDR_SAG_LEVEL);
	wire wrStatus = regWrEn && (regAddr == `LPAS_ADDR_PRIMARY_STATUS);
	wire wrMask = regWrEn && (regAddr == `LPAS_ADDR_PRIMARY_MASK);
	wire wrCompMode = regWrEn && (regAddr == `LPAS_ADDR_COMPUTE_MODE);
	wire wrAccum = regWrEn && (regAddr == `LPAS_ADDR_ACCUM_CONFIG);
	wire wrSagCyc = regWrEn && (regAddr == `LPAS_ADDR_SAG_CYCLES);
	wire sagMode = accumulation_config_q[`LPAS_BIT_SAG_MODE];

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			sag_level_q <= `LPAS_RST_SAG_LEVEL;
			sag_half_cycle_count_q <= `LPAS_RST_SAG_CYCLES;
			accumulation_config_q <= `LPAS_RST_ACCUM_CONFIG;
			delay_pair_select_q <= `LPAS_RST_SELECT;
			sagMask_q <= `LPAS_RST_MASK;
		end else begin
			if (wrSagLevel)
				sag_level_q <= regWrData[23:0];
			if (wrSagCyc)
				sag_half_cycle_count_q <= regWrData[7:0];
			if (wrAccum)
				accumulation_config_q <= regWrData[7:0];
			if (wrCompMode)
				delay_pair_select_q <= regWrData[`LPAS_BIT_SEL_LO+1:`LPAS_BIT_SEL_LO];
			if (wrMask)
				sagMask_q <= regWrData[`LPAS_BIT_SAG];
		end
	end

	// delay and period measurement between rising crossings
	wire [1:0] selRaw = delay_pair_select_q;
	wire selVI = (selRaw == lpas_pkg::SEL_VOLT_CURR);
	wire selVV = (selRaw == lpas_pkg::SEL_VOLT_VOLT);
	wire selII = (selRaw == lpas_pkg::SEL_CURR_CURR);
	logic [15:0] delayRes_q [3];
	logic [15:0] periodRes_q [3];

	genvar k;
	generate
		for (k = 0; k < 3; k++) begin : g_phase
			// pairs A-C, B-C, A-B
			localparam int START_IDX = (k == 2) ? 0 : k;
			localparam int STOP_IDX = (k == 2) ? 1 : 2;
			logic [15:0] dCnt_q;
			logic dRun_q;
			logic [15:0] pCnt_q;
			wire startEv = (selVI && zxVoltRise[k]) || (selVV && zxVoltRise[START_IDX])
				|| (selII && zxCurrRise[START_IDX]);
			wire stopEv = (selVI && zxCurrRise[k]) || (selVV && zxVoltRise[STOP_IDX])
				|| (selII && zxCurrRise[STOP_IDX]);
			wire dSat = (dCnt_q == 16'hFFFF);
			wire pSat = (pCnt_q == 16'hFFFF);

			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					dCnt_q <= 16'h0000;
					dRun_q <= 1'b0;
					delayRes_q[k] <= 16'h0000;
				end else if (wrCompMode) begin
					// a new pairing discards the half-finished interval
					dRun_q <= 1'b0;
				end else if (dRun_q && stopEv) begin
					delayRes_q[k] <= dCnt_q;
					dRun_q <= 1'b0;
				end else if (startEv) begin
					dCnt_q <= 16'h0000;
					dRun_q <= 1'b1;
				end else if (dRun_q && tick_q && !dSat) begin
					dCnt_q <= dCnt_q + 16'h0001;
				end
			end

			always_ff @(posedge sys_clk) begin
				if (!rst_n) begin
					pCnt_q <= 16'h0000;
					periodRes_q[k] <= 16'h0000;
				end else if (zxVoltRise[k]) begin
					periodRes_q[k] <= pCnt_q;
					pCnt_q <= 16'h0000;
				end else if (tick_q && !pSat) begin
					pCnt_q <= pCnt_q + 16'h0001;
				end
			end
		end
	endgenerate

	// sag detection on the absolute voltage
	wire [23:0] absA = phaseVoltA[23] ? 24'(-phaseVoltA) : phaseVoltA;
	wire [23:0] absB = phaseVoltB[23] ? 24'(-phaseVoltB) : phaseVoltB;
	wire [23:0] absC = phaseVoltC[23] ? 24'(-phaseVoltC) : phaseVoltC;
	wire [2:0] belowLevel = {absC < sag_level_q, absB < sag_level_q, absA < sag_level_q};
	wire [2:0] halfCycle = zxVoltRise | zxVoltFall;
	wire [2:0] underFlag;
	wire [2:0] sagEvent;

	generate
		for (k = 0; k < 3; k++) begin : g_sag
			lpas_sag_phase u_sag (
				.sys_clk(sys_clk),
				.rst_n(rst_n),
				.halfCycle(halfCycle[k]),
				.belowLevel(belowLevel[k]),
				.sagCycles(sag_half_cycle_count_q),
				.restart(wrSagCyc),
				.flagMode(sagMode),
				.underFlag(underFlag[k]),
				.sagEvent(sagEvent[k])
			);
		end
	endgenerate

	// sticky sag status: a new event wins over the host clear
	wire sagSet = |sagEvent;
	wire sagClr = wrStatus && regWrData[`LPAS_BIT_SAG];

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			sagStatus_q <= 1'b0;
		else if (sagSet)
			sagStatus_q <= 1'b1;
		else if (sagClr)
			sagStatus_q <= 1'b0;
	end

	assign event_interrupt_n = !(sagStatus_q && sagMask_q);

	// read path, one cycle latency, unmapped reads zero
	wire [31:0] statusWord = 32'(sagStatus_q) << `LPAS_BIT_SAG;
	wire [31:0] maskWord = 32'(sagMask_q) << `LPAS_BIT_SAG;
	wire [31:0] phaseWord = 32'(underFlag) << `LPAS_BIT_FLAG_LO;
	wire [31:0] selWord = 32'(delay_pair_select_q) << `LPAS_BIT_SEL_LO;
	wire [31:0] rdMux =
		(regAddr == `LPAS_ADDR_SAG_LEVEL) ? {8'h00, sag_level_q} :
		(regAddr == `LPAS_ADDR_PRIMARY_STATUS) ? statusWord :
		(regAddr == `LPAS_ADDR_PRIMARY_MASK) ? maskWord :
		(regAddr == `LPAS_ADDR_PHASE_STATUS) ? phaseWord :
		(regAddr == `LPAS_ADDR_DELAY_FIRST) ? {16'h0000, delayRes_q[0]} :
		(regAddr == `LPAS_ADDR_DELAY_SECOND) ? {16'h0000, delayRes_q[1]} :
		(regAddr == `LPAS_ADDR_DELAY_THIRD) ? {16'h0000, delayRes_q[2]} :
		(regAddr == `LPAS_ADDR_COMPUTE_MODE) ? selWord :
		(regAddr == `LPAS_ADDR_ACCUM_CONFIG) ? {24'h000000, accumulation_config_q} :
		(regAddr == `LPAS_ADDR_SAG_CYCLES) ? {24'h000000, sag_half_cycle_count_q} :
		(regAddr == `LPAS_ADDR_PERIOD_A) ? {16'h0000, periodRes_q[0]} :
		(regAddr == `LPAS_ADDR_PERIOD_B) ? {16'h0000, periodRes_q[1]} :
		(regAddr == `LPAS_ADDR_PERIOD_C) ? {16'h0000, periodRes_q[2]} :
		32'h00000000;

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdData_q <= 32'h00000000;
			rdValid_q <= 1'b0;
		end else begin
			rdValid_q <= regRdEn;
			if (regRdEn)
				rdData_q <= rdMux;
		end
	end

	assign regRdData = rdData_q;
	assign regRdValid = rdValid_q;
endmodule

// [verilog/lpas_params.svh]
`ifndef LPAS_PARAMS_SVH
`define LPAS_PARAMS_SVH
// Contract
// - select 10 measures current pairs A-C, B-C, A-B
// - delay results 16-bit unsigned, 256 kHz ticks
// - three period registers refreshed every line period
// - period counts in 3.90625 us ticks
// - compare absolute phase voltage against sag level
// - per-phase under-level flags in status bits 14:12
// - mode 0 sets sag after full below period
// - mode 1 sets sag after below then above
// - mode 0 sag sets phase flag and pulls interrupt low
// - write one clears sag, releases interrupt, keeps flags
// - mode 0 re-sets sag after further below period
// - mode 1 continued below leaves sag clear
// - mode 1 rise sets sag, clears phase flag
// - flag set after below period, cleared after above
// - 8-bit half-cycle count, zero not allowed; zero is stored and acts as one
// - delays start and stop on rising crossings
// - interrupt only when mask sag bit set
// - count register write restarts half-cycle counter

// register addresses
`define LPAS_ADDR_SAG_LEVEL 16'hE509
`define LPAS_ADDR_PRIMARY_STATUS 16'hE502
`define LPAS_ADDR_PRIMARY_MASK 16'hE50B
`define LPAS_ADDR_PHASE_STATUS 16'hE600
`define LPAS_ADDR_DELAY_FIRST 16'hE601
`define LPAS_ADDR_DELAY_SECOND 16'hE602
`define LPAS_ADDR_DELAY_THIRD 16'hE603
`define LPAS_ADDR_COMPUTE_MODE 16'hE60E
`define LPAS_ADDR_ACCUM_CONFIG 16'hE701
`define LPAS_ADDR_SAG_CYCLES 16'hE704
`define LPAS_ADDR_PERIOD_A 16'hE905
`define LPAS_ADDR_PERIOD_B 16'hE906
`define LPAS_ADDR_PERIOD_C 16'hE907

// field positions
`define LPAS_BIT_SAG 16
`define LPAS_BIT_FLAG_LO 12
`define LPAS_BIT_SAG_MODE 6
`define LPAS_BIT_SEL_LO 9

// reset values
`define LPAS_RST_SAG_LEVEL 24'h000000
`define LPAS_RST_SAG_CYCLES 8'h01
`define LPAS_RST_ACCUM_CONFIG 8'h00
`define LPAS_RST_SELECT 2'h0
`define LPAS_RST_MASK 1'b0

// time base: 3.90625 us per tick
`define LPAS_CLK_KHZ 20000
`define LPAS_TICK_KHZ 256
`endif

// [verilog/lpas_pkg.sv]
package lpas_pkg;
	typedef enum logic [1:0] {
		SEL_VOLT_CURR = 2'h0,
		SEL_VOLT_VOLT = 2'h1,
		SEL_CURR_CURR = 2'h2,
		SEL_RESERVED = 2'h3
	} lpas_delay_sel_e;
endpackage

// [verilog/lpas_sag_phase.sv]
`include "lpas_params.svh"
module lpas_sag_phase (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// line events
	input wire logic halfCycle,
	input wire logic belowLevel,
	// configuration
	input wire logic [7:0] sagCycles,
	input wire logic restart,
	input wire logic flagMode,
	// results
	output logic underFlag,
	output logic sagEvent
);
	logic [7:0] cnt_q;
	logic allBelow_q;
	logic allAbove_q;
	logic flag_q;
	logic event_q;

	wire [8:0] cntNext = {1'b0, cnt_q} + 9'h001;
	// a count of zero behaves as one rather than never ending
	wire periodEnd = halfCycle && (cntNext >= {1'b0, sagCycles});
	wire belowNow = allBelow_q && belowLevel;
	wire aboveNow = allAbove_q && !belowLevel;
	wire eventD = flagMode ? (periodEnd && aboveNow && flag_q)
		: (periodEnd && belowNow);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cnt_q <= 8'h00;
			allBelow_q <= 1'b1;
			allAbove_q <= 1'b1;
			flag_q <= 1'b0;
			event_q <= 1'b0;
		end else begin
			event_q <= eventD;
			if (restart || periodEnd) begin
				cnt_q <= 8'h00;
				allBelow_q <= 1'b1;
				allAbove_q <= 1'b1;
			end else begin
				if (halfCycle)
					cnt_q <= cntNext[7:0];
				allBelow_q <= belowNow;
				allAbove_q <= aboveNow;
			end
			if (periodEnd && !restart) begin
				if (belowNow)
					flag_q <= 1'b1;
				else if (aboveNow)
					flag_q <= 1'b0;
			end
		end
	end

	assign underFlag = flag_q;
	assign sagEvent = event_q && !restart;
endmodule
